// ==== verilog/gicr_regs.v ====
// Purpose: Pin control, part identifier and channel register bank behind AXI4-Lite
// Assumes: One clock clk_sys at 20 MHz, asynchronous active-high reset rst
// Notes: Sequencer steps through enabled channels after a fixed dwell
//
// Functional notes
// - Bit 4 makes pin 0 an input
// - Bit 3 makes pin 1 drive out
// - Bit 2 makes pin 0 drive out
// - Bit 1: pin 1 level, out or in
// - Bit 0: pin 0 level, out or in
// - Bit 5 makes pin 1 an input
// - Read-only 16-bit identifier at index 0x07
// - Channel 0 resets to 0x8001, enabled
// - Bit 15 enables; several enabled are sequenced
// - Ascending order; channels 1-15 reset disabled
// - Bits 14:12 pick one of eight setups
// - A setup's four registers apply together
// - Bits 11:10 reserved, read zero, write zero
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gicr_map.vh"

module gicr_regs (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // AXI4-Lite write address
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // General pin 0
   input wire general_pin_0_in,
   output reg general_pin_0_out,
   output reg general_pin_0_oe_n,
   // General pin 1
   input wire general_pin_1_in,
   output reg general_pin_1_out,
   output reg general_pin_1_oe_n,
   // Sequencer towards the converter core
   output reg [3:0] seq_channel,
   output reg [2:0] seq_profile,
   output reg seq_active,
   output reg seq_profile_load
);

// ***********************************
// Helpers
// ***********************************
function [`GICR_ADDR_W-1:0] word_index;
   input [31:0] addr;
   begin
      word_index = addr[`GICR_ADDR_W+1:2];
   end
endfunction

function is_channel;
   input [`GICR_ADDR_W-1:0] idx;
   begin
      is_channel = (idx >= `GICR_IDX_CH0) && (idx <= `GICR_IDX_CH_LAST);
   end
endfunction

function [15:0] merge16;
   input [15:0] old;
   input [31:0] data;
   input [3:0] strb;
   begin
      merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   end
endfunction

// ***********************************
// State
// ***********************************
reg [15:0] chan_cfg [0:`GICR_NUM_CH-1];
reg pin0_input_enable;
reg pin1_input_enable;
reg pin0_output_enable;
reg pin1_output_enable;
reg pin0_level;
reg pin1_level;
wire [1:0] pin_sampled;
reg [31:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;
reg [7:0] dwell;
integer i;

gicr_pin_sync u_pin_sync (
   .clk_sys(clk_sys),
   .rst(rst),
   .pin_raw({general_pin_1_in, general_pin_0_in}),
   .pin_level(pin_sampled)
);

// ***********************************
// Write path
// ***********************************
assign s_axi_awready = !aw_held && !s_axi_bvalid;
assign s_axi_wready = !w_held && !s_axi_bvalid;

wire aw_now = s_axi_awvalid && s_axi_awready;
wire w_now = s_axi_wvalid && s_axi_wready;
wire have_aw = aw_held || aw_now;
wire have_w = w_held || w_now;
wire do_write = have_aw && have_w && !s_axi_bvalid;
wire [31:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
wire [`GICR_ADDR_W-1:0] wr_idx = word_index(wr_addr);
wire wr_hit = (wr_addr[31:`GICR_ADDR_W+2] == 0) && (is_channel(wr_idx) || (wr_idx == `GICR_IDX_PINCTL));
wire [15:0] pin_word = {10'h000, pin1_input_enable, pin0_input_enable, pin1_output_enable,
   pin0_output_enable, pin1_level, pin0_level};
wire [15:0] pin_new = merge16(pin_word, wr_data, wr_strb) & `GICR_PINCTL_MASK;
wire [3:0] wr_ch = wr_idx[3:0];

always @(posedge clk_sys or posedge rst) begin
   if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GICR_RESP_OKAY;
      pin0_input_enable <= 1'b0;
      pin1_output_enable <= 1'b0;
      pin0_output_enable <= 1'b0;
      pin1_level <= 1'b0;
      pin0_level <= 1'b0;
      pin1_input_enable <= 1'b0;
      // Only channel 0 comes out of reset enabled
      chan_cfg[0] <= `GICR_CH0_RESET;
      for (i = 1; i < `GICR_NUM_CH; i = i + 1) begin
         chan_cfg[i] <= `GICR_CHN_RESET;
      end
   end else begin
      // A half that arrives alone is parked until its partner shows up
      if (aw_now && !do_write) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      if (w_now && !do_write) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `GICR_RESP_OKAY : `GICR_RESP_SLVERR;
         if (wr_hit && wr_idx == `GICR_IDX_PINCTL) begin
            pin0_level <= pin_new[`GICR_PIN_LVL0];
            pin1_level <= pin_new[`GICR_PIN_LVL1];
            pin0_output_enable <= pin_new[`GICR_PIN_OE0];
            pin1_output_enable <= pin_new[`GICR_PIN_OE1];
            pin0_input_enable <= pin_new[`GICR_PIN_IE0];
            pin1_input_enable <= pin_new[`GICR_PIN_IE1];
         end else if (wr_hit) begin
            // Reserved bits are dropped even if software sets them
            chan_cfg[wr_ch] <= merge16(chan_cfg[wr_ch], wr_data, wr_strb) & `GICR_CH_WMASK;
         end
      end
   end
end

// ***********************************
// Read path
// ***********************************
assign s_axi_arready = !s_axi_rvalid;
wire [`GICR_ADDR_W-1:0] rd_idx = word_index(s_axi_araddr);
wire rd_upper_ok = (s_axi_araddr[31:`GICR_ADDR_W+2] == 0);
// An input pin reports its sampled level instead of the stored drive value
wire lvl0_view = pin0_input_enable ? pin_sampled[0] : pin0_level;
wire lvl1_view = pin1_input_enable ? pin_sampled[1] : pin1_level;
reg [15:0] rd_word;
reg rd_hit;

always @* begin
   rd_word = 16'h0000;
   rd_hit = rd_upper_ok;
   if (!rd_upper_ok) begin
      rd_hit = 1'b0;
   end else if (rd_idx == `GICR_IDX_PINCTL) begin
      rd_word = {10'h000, pin1_input_enable, pin0_input_enable, pin1_output_enable,
         pin0_output_enable, lvl1_view, lvl0_view};
   end else if (rd_idx == `GICR_IDX_PARTID) begin
      rd_word = `GICR_PART_ID;
   end else if (is_channel(rd_idx)) begin
      rd_word = chan_cfg[rd_idx[3:0]] & `GICR_CH_WMASK;
   end else if (rd_idx == `GICR_IDX_SEQ) begin
      rd_word = {8'h00, seq_active, seq_profile, seq_channel};
   end else begin
      rd_hit = 1'b0;
   end
end

always @(posedge clk_sys or posedge rst) begin
   if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `GICR_RESP_OKAY;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? `GICR_RESP_OKAY : `GICR_RESP_SLVERR;
   end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
   end
end

// ***********************************
// Pin drivers
// ***********************************
// An input enable overrides the output enable so the pin is never fought over
always @(posedge clk_sys or posedge rst) begin
   if (rst) begin
      general_pin_0_out <= 1'b0;
      general_pin_1_out <= 1'b0;
      general_pin_0_oe_n <= 1'b1;
      general_pin_1_oe_n <= 1'b1;
   end else begin
      general_pin_0_out <= pin0_level;
      general_pin_1_out <= pin1_level;
      general_pin_0_oe_n <= !(pin0_output_enable && !pin0_input_enable);
      general_pin_1_oe_n <= !(pin1_output_enable && !pin1_input_enable);
   end
end

// ***********************************
// Channel sequencer
// ***********************************
// Finds the next enabled channel above the current one, wrapping round
// The current channel is probed last, so a lone enabled channel steps onto itself
reg [3:0] next_channel;
reg found;
reg [4:0] k;
reg [3:0] probe;
wire [15:0] cur_cfg = chan_cfg[seq_channel];

always @* begin
   next_channel = seq_channel;
   found = 1'b0;
   probe = 4'h0;
   for (k = 5'h01; k <= 5'h10; k = k + 5'h01) begin
      probe = seq_channel + k[3:0];
      if (!found && chan_cfg[probe][`GICR_CH_EN]) begin
         next_channel = probe;
         found = 1'b1;
      end
   end
end

always @(posedge clk_sys or posedge rst) begin
   if (rst) begin
      seq_channel <= 4'h0;
      seq_profile <= 3'h0;
      seq_active <= 1'b0;
      seq_profile_load <= 1'b0;
      dwell <= 8'h00;
   end else begin
      seq_profile_load <= 1'b0;
      seq_active <= found;
      if (!found) begin
         dwell <= 8'h00;
      end else if (!cur_cfg[`GICR_CH_EN] || dwell == `GICR_DWELL_CYCLES) begin
         // A channel switched off under the sequencer is left at once, without dwell
         // Step on; the profile number loads the whole setup at once
         dwell <= 8'h00;
         seq_channel <= next_channel;
         seq_profile <= chan_cfg[next_channel][`GICR_CH_SEL_HI:`GICR_CH_SEL_LO];
         seq_profile_load <= 1'b1;
      end else begin
         dwell <= dwell + 8'h01;
      end
   end
end

endmodule // gicr_regs

// ==== inc/gicr_map.vh ====
// Purpose: Register map and field layout of the pin, identifier and channel bank
// Assumes: 32-bit AXI4-Lite words, byte address = 4 * register index
// Notes: Definitions only
`ifndef GICR_MAP_VH
`define GICR_MAP_VH

// ***********************************
// Register indices and address width
// ***********************************
`define GICR_IDX_PINCTL 8'h06
`define GICR_IDX_PARTID 8'h07
`define GICR_IDX_CH0 8'h10
`define GICR_IDX_CH_LAST 8'h1f
`define GICR_IDX_SEQ 8'h20
`define GICR_ADDR_W 8

// ***********************************
// Pin control fields
// ***********************************
`define GICR_PIN_LVL0 0
`define GICR_PIN_LVL1 1
`define GICR_PIN_OE0 2
`define GICR_PIN_OE1 3
`define GICR_PIN_IE0 4
`define GICR_PIN_IE1 5
`define GICR_PINCTL_MASK 16'h003f

// ***********************************
// Channel register fields
// ***********************************
`define GICR_CH_EN 15
`define GICR_CH_SEL_HI 14
`define GICR_CH_SEL_LO 12
`define GICR_CH_WMASK 16'hf3ff
`define GICR_CH0_RESET 16'h8001
`define GICR_CHN_RESET 16'h0001
`define GICR_NUM_CH 16

// ***********************************
// Identifier and sequencing
// ***********************************
`define GICR_PART_ID 16'h5a50
`define GICR_DWELL_CYCLES 8'h0f

// ***********************************
// AXI responses
// ***********************************
`define GICR_RESP_OKAY 2'b00
`define GICR_RESP_SLVERR 2'b10

`endif

// ==== verilog/gicr_pin_sync.v ====
// Purpose: Three-stage synchroniser for the two general pin inputs
// Assumes: Pins are asynchronous to clk_sys
// Notes: A change counts once the second and third stages agree
`timescale 1ns/1ps

module gicr_pin_sync (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Raw pins
   input wire [1:0] pin_raw,
   // Filtered levels
   output reg [1:0] pin_level
);

reg [1:0] stage1;
reg [1:0] stage2;
reg [1:0] stage3;

always @(posedge clk_sys or posedge rst) begin
   if (rst) begin
      stage1 <= 2'h0;
      stage2 <= 2'h0;
      stage3 <= 2'h0;
      pin_level <= 2'h0;
   end else begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
      // Per bit: hold the old level while the two stages disagree
      pin_level <= (stage2 & stage3) | (pin_level & (stage2 ^ stage3));
   end
end

endmodule // gicr_pin_sync

// ==== verif/gicr_regs_checker.sv ====
// Purpose: Bus handshake, field and sequencer checks on the register bank ports
// Assumes: One clock clk_sys, asynchronous active-high rst
// Notes: Bound to gicr_regs from tb_top
`timescale 1ns/1ps

module gicr_regs_checker (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Write channels
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Read channels
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Sequencer
   input wire [3:0] seq_channel,
   input wire seq_profile_load
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ****************
   // Sequences
   // ****************
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   // ****************
   // Assertions
   // ****************
   a_write_answer: assert property (wr_both |=> s_axi_bvalid) else $error("no write response");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid) else $error("no read data");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && !s_axi_rresp[0])
      else $error("upper read bits set");
   a_ident_code: assert property (rd_taken ##0 (s_axi_araddr == 32'h1c) |=> s_axi_rdata[15:4] == 12'h5a5)
      else $error("identifier wrong");
   a_resv_zero: assert property (rd_taken ##0 (s_axi_araddr[31:6] == 26'h1) |=> s_axi_rdata[11:10] == 2'b00)
      else $error("reserved bits set");
   a_step_pulse: assert property (seq_profile_load |=> !seq_profile_load) else $error("load not a pulse");
   a_chan_step: assert property (seq_channel != $past(seq_channel) |-> seq_profile_load)
      else $error("channel moved without load");
endmodule // gicr_regs_checker

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the pin, identifier and channel bank
// Assumes: AXI4-Lite master tasks, 50 ns clock
// Notes: Row table first, then channel 1 profile field, pins, sequencer and reset
`timescale 1ns/1ps

module tb_top;
   typedef struct packed {logic w; logic [31:0] a; logic [15:0] d; logic [15:0] m; logic [15:0] e; logic [1:0] r;}
      gicr_row_t;
   logic clk_sys = 0;
   logic rst = 1;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, first;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic pin0_in = 0, pin1_in = 0, pin0_out, pin1_out, pin0_oe_n, pin1_oe_n, seq_active, seq_load;
   logic [3:0] seq_channel, prev;
   logic [2:0] seq_profile;
   integer error_cnt = 0, compares = 0, k, cnt, gap;
   // Identifier rows mask the low nibble, which the part leaves undefined
   gicr_row_t rows [0:8] = '{'{0, 32'h18, 0, 16'hffff, 16'h0000, 0}, '{0, 32'h40, 0, 16'hffff, 16'h8001, 0},
      '{0, 32'h44, 0, 16'hffff, 16'h0001, 0}, '{0, 32'h7c, 0, 16'hffff, 16'h0001, 0},
      '{0, 32'h1c, 0, 16'hfff0, 16'h5a50, 0}, '{1, 32'h40, 16'hffff, 0, 0, 0},
      '{0, 32'h40, 0, 16'hffff, 16'hf3ff, 0}, '{0, 32'h100, 0, 16'hffff, 16'h0000, 2'b10},
      '{1, 32'h104, 16'h5555, 0, 0, 2'b10}};

   gicr_regs i_gicr_regs (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .general_pin_0_in(pin0_in),
      .general_pin_0_out(pin0_out), .general_pin_0_oe_n(pin0_oe_n), .general_pin_1_in(pin1_in),
      .general_pin_1_out(pin1_out), .general_pin_1_oe_n(pin1_oe_n), .seq_channel, .seq_profile, .seq_active,
      .seq_profile_load(seq_load));

   // ****************
   // Tasks
   // ****************
   task chk(input [31:0] got, input [31:0] exp);
      begin
         compares++;
         if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task stop_test;
      begin
         $display("errors %0d compares %0d", error_cnt, compares);
         if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
         else $display("TEST FAILED");
         $finish;
      end
   endtask
   task tick(inout integer n);
      begin
         @(posedge clk_sys);
         n++;
         if (n > 40) begin
            error_cnt++;
            stop_test;
         end
      end
   endtask
   task axw(input [31:0] a, input [15:0] d, output [1:0] r);
      integer n;
      logic aw, w, b;
      begin
         @(posedge clk_sys);
         n = 0;
         aw = 1;
         w = 1;
         b = 1;
         s_axi_awaddr <= a;
         s_axi_wdata <= {16'h0000, d};
         while (aw || w || b) begin
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= b;
            tick(n);
            if (aw && s_axi_awready) aw = 0;
            if (w && s_axi_wready) w = 0;
            if (b && s_axi_bvalid) begin
               b = 0;
               r = s_axi_bresp;
            end
         end
         s_axi_bready <= 1'b0;
      end
   endtask
   task axr(input [31:0] a, output [31:0] d, output [1:0] r);
      integer n;
      logic ar, rr;
      begin
         @(posedge clk_sys);
         n = 0;
         ar = 1;
         rr = 1;
         s_axi_araddr <= a;
         while (ar || rr) begin
            s_axi_arvalid <= ar;
            s_axi_rready <= rr;
            tick(n);
            if (ar && s_axi_arready) ar = 0;
            if (rr && s_axi_rvalid) begin
               rr = 0;
               d = s_axi_rdata;
               r = s_axi_rresp;
            end
         end
         s_axi_rready <= 1'b0;
      end
   endtask

   // ****************
   // Sequence
   // ****************
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rows[i]) begin
         if (rows[i].w) axw(rows[i].a, rows[i].d, resp);
         else axr(rows[i].a, rdat, resp);
         chk(resp, rows[i].r);
         if (!rows[i].w) chk(rdat & rows[i].m, rows[i].e);
      end
      for (k = 0; k < 8; k++) begin
         axw(32'h44, {1'b1, k[2:0], 12'h001}, resp);
         axr(32'h44, rdat, resp);
         chk(rdat, {16'h0000, 1'b1, k[2:0], 12'h001});
      end
      axw(32'h18, 16'h000e, resp);
      repeat (2) @(posedge clk_sys);
      chk({pin1_oe_n, pin0_oe_n, pin1_out, pin0_out}, 4'b0010);
      pin0_in <= 1'b1;
      axw(32'h18, 16'h0036, resp);
      repeat (6) @(posedge clk_sys);
      chk({pin1_oe_n, pin0_oe_n}, 2'b11);
      axr(32'h18, rdat, resp);
      chk(rdat, 32'h35);
      axw(32'h40, 16'ha001, resp);
      axw(32'h44, 16'h0001, resp);
      axw(32'h4c, 16'hd001, resp);
      first = 1;
      cnt = 0;
      gap = 0;
      repeat (100) begin
         @(posedge clk_sys);
         #1;
         gap++;
         if (seq_load) begin
            if (!first) chk(seq_channel, prev == 0 ? 3 : 0);
            if (!first) chk(gap, 16);
            chk(seq_profile, seq_channel == 3 ? 5 : 2);
            chk(seq_active, 1'b1);
            prev = seq_channel;
            first = 0;
            gap = 0;
            cnt++;
         end
      end
      chk(cnt >= 3, 1);
      // Drive both pins out first, so the mid-run reset has something to undo
      axw(32'h18, 16'h000f, resp);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk({pin1_oe_n, pin0_oe_n, pin1_out, pin0_out}, 4'b1100);
      rst <= 1'b0;
      axr(32'h18, rdat, resp);
      chk(rdat, 32'h0000);
      axr(32'h40, rdat, resp);
      chk(rdat, 32'h8001);
      axr(32'h4c, rdat, resp);
      chk(rdat, 32'h0001);
      // With channel 0 switched off nothing is enabled and the sequencer idles
      axw(32'h40, 16'h0001, resp);
      repeat (3) @(posedge clk_sys);
      chk(seq_active, 1'b0);
      axr(32'h80, rdat, resp);
      chk(rdat, 32'h0000);
      chk(resp, 2'b00);
      stop_test;
   end
endmodule // tb_top

bind gicr_regs gicr_regs_checker i_gicr_regs_checker (.clk_sys, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seq_channel, .seq_profile_load);
